/* logic/iopvr_port.sv */
/*
 * Sixteen-pin general-purpose I/O port with its word-organised variable
 * RAM (three I/O words, thirteen general words) and an optional second
 * bank of the three I/O words for a second group of sixteen pins.
 * Assumes: a classic Wishbone master on clk_i, pads resolved outside
 * from the output and enable signals, pin levels asynchronous to clk_i.
 * The bus answers every request after one edge, mapped or not, so a
 * master never stalls on a stray address.
 * Pad outputs trail the stored words by one edge; the input word
 * trails the pins by two edges through the synchronisers.
 */
// The placing of the registers and the Wishbone interface to the registers were decided locally.
module iopvr_port
    import iopvr_pkg::*;
#(
    parameter bit AUX_BANK_EN = 1'b1
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // classic wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [12:0] adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // main pin group
    input  wire logic [15:0] pin_in_i,
    output logic      [15:0] pin_o,
    output logic      [15:0] pin_oe_o,
    // auxiliary pin group
    input  wire logic [15:0] aux_pin_in_i,
    output logic      [15:0] aux_pin_o,
    output logic      [15:0] aux_pin_oe_o,
    output logic             aux_selected_o
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // shift of a field inside its word; positions past the field count
    // are caught by field_ok
    function automatic logic [3:0] field_shift(input logic [1:0] grn,
                                               input logic [3:0] pos);
        logic [3:0] sh;
        sh = 4'h0;
        unique case (grn)
            GRN_WORD:   sh = 4'h0;
            GRN_BYTE:   sh = {pos[0], 3'b000};
            GRN_NIBBLE: sh = {pos[1:0], 2'b00};
            GRN_BIT:    sh = pos;
        endcase
        return sh;
    endfunction

    function automatic logic [15:0] field_mask(input logic [1:0] grn,
                                               input logic [3:0] pos);
        logic [15:0] base;
        base = MASK_WORD;
        unique case (grn)
            GRN_WORD:   base = MASK_WORD;
            GRN_BYTE:   base = MASK_BYTE;
            GRN_NIBBLE: base = MASK_NIBBLE;
            GRN_BIT:    base = MASK_BIT;
        endcase
        return base << field_shift(grn, pos);
    endfunction

    // a word access must name position 0, a byte 0 or 1, a nibble 0 to 3
    function automatic logic field_ok(input logic [1:0] grn,
                                      input logic [3:0] pos);
        logic ok;
        ok = 1'b0;
        unique case (grn)
            GRN_WORD:   ok = (pos == 4'h0);
            GRN_BYTE:   ok = (pos[3:1] == 3'b000);
            GRN_NIBBLE: ok = (pos[3:2] == 2'b00);
            GRN_BIT:    ok = 1'b1;
        endcase
        return ok;
    endfunction

    // ------------------------------------------------------------------
    // pin input synchronisers
    // ------------------------------------------------------------------
    logic [15:0] pin_meta;
    logic [15:0] pin_sync;
    logic [15:0] aux_meta;
    logic [15:0] aux_sync;

    // pin levels sampled
    // no reset: the chain flushes within the two reset edges
    always_ff @(posedge clk_i) begin
        pin_meta <= pin_in_i;
        pin_sync <= pin_meta;
    end

    // second group synchronised even when absent, so the read path
    // needs no special case; the flops go unused then
    always_ff @(posedge clk_i) begin
        aux_meta <= aux_pin_in_i;
        aux_sync <= aux_meta;
    end

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    logic [15:0] main_latch;
    logic [15:0] main_dir;
    // both banks always exist in storage; AUX_BANK_EN only gates their
    // use, so the unused copy is left for synthesis to trim
    logic [15:0] aux_latch;
    logic [15:0] aux_dir;
    logic        bank_aux;
    logic [15:0] gp_mem [GP_WORDS];

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    wire        req       = cyc_i & stb_i & ~ack_o;
    wire [10:0] word_adr  = adr_i[12:2];
    // word map at the bottom, bank command and status just above it
    wire        in_words  = (adr_i[12:6] == OFF_WORD_BASE[12:6]);
    wire        in_field  = (adr_i[12] == OFF_FIELD_BASE[12]);
    wire        hit_cmd   = ({adr_i[12:2], 2'b00} == OFF_BANK_CMD);
    wire        hit_stat  = ({adr_i[12:2], 2'b00} == OFF_BANK_STAT);

    // field window, byte address bits:
    //   [12]    window select
    //   [11:10] granule: word, byte, nibble, bit
    //   [9:6]   RAM word, 0 to 15
    //   [5:2]   field position inside the word
    // every address bit from 12 down to 2 is used, so a bad position is the only thing
    // the window refuses
    wire [1:0]  fld_grn   = word_adr[FLD_GRN_LSB +: 2];
    wire [3:0]  fld_word  = word_adr[FLD_WRD_LSB +: 4];
    wire [3:0]  fld_pos   = word_adr[FLD_POS_LSB +: 4];

    wire        field_hit = in_field & field_ok(fld_grn, fld_pos);

    // word selected by either map
    wire [3:0]  acc_word  = in_words ? adr_i[5:2] : fld_word;

    wire [15:0] lane_mask = {{8{sel_i[1]}}, {8{sel_i[0]}}};
    wire [3:0]  acc_shift = in_words ? 4'h0
                                     : field_shift(fld_grn, fld_pos);
    wire [15:0] acc_mask  = in_words ? lane_mask
                                     : field_mask(fld_grn, fld_pos);
    wire        acc_hit   = in_words | field_hit;

    // ------------------------------------------------------------------
    // word read mux
    // ------------------------------------------------------------------
    // bank switched into I/O slots
    wire [15:0] cur_input = bank_aux ? aux_sync  : pin_sync;
    wire [15:0] cur_latch = bank_aux ? aux_latch : main_latch;
    wire [15:0] cur_dir   = bank_aux ? aux_dir   : main_dir;
    // only used for words 3 to 15, so the index stays in 0 to 12
    wire [3:0]  gp_index  = acc_word - WIDX_GP0;

    logic [15:0] word_value;

    // three I/O words then general words
    always_comb begin
        unique case (acc_word)
            WIDX_INPUT: word_value = cur_input;
            WIDX_LATCH: word_value = cur_latch;
            WIDX_DIR:   word_value = cur_dir;
            default:    word_value = gp_mem[gp_index];
        endcase
    end

    // reads the addressed word: the pins in word 0, the latch in word 1
    wire [15:0] field_rd = (word_value & acc_mask) >> acc_shift;

    // ------------------------------------------------------------------
    // status word
    // ------------------------------------------------------------------
    // bit 1 tells software whether the second bank exists at all
    wire [15:0] stat_rd  = 16'(
        (32'(bank_aux) << STAT_AUX_SEL)
        | (32'(AUX_BANK_EN) << STAT_AUX_AVAIL));

    wire [31:0] next_dat = acc_hit  ? {16'h0000, field_rd}
                         : hit_stat ? {16'h0000, stat_rd}
                         : 32'h0000_0000;

    // ------------------------------------------------------------------
    // write path
    // ------------------------------------------------------------------
    wire        do_write  = req & we_i;
    wire [15:0] wr_aligned = (dat_i[15:0] << acc_shift) & acc_mask;
    wire [15:0] wr_merged  = (word_value & ~acc_mask) | wr_aligned;

    wire        wr_latch = do_write & acc_hit & (acc_word == WIDX_LATCH);
    wire        wr_dir   = do_write & acc_hit & (acc_word == WIDX_DIR);
    wire        wr_gp    = do_write & acc_hit & (acc_word >= WIDX_GP0);
    wire        wr_cmd   = do_write & hit_cmd & sel_i[0];

    wire        wr_main  = ~bank_aux;
    wire        wr_aux   = bank_aux & AUX_BANK_EN;

    // per-copy strobes; a write reaches exactly one bank
    wire        wr_main_latch = wr_latch & wr_main;
    wire        wr_main_dir   = wr_dir   & wr_main;
    wire        wr_aux_latch  = wr_latch & wr_aux;
    wire        wr_aux_dir    = wr_dir   & wr_aux;

    // ------------------------------------------------------------------
    // bank select
    // ------------------------------------------------------------------
    // the select only swaps what the bus sees in words 0 to 2; both pin
    // groups keep running from their own latch and direction copies
    logic next_bank;

    always_comb begin
        next_bank = bank_aux;
        if (wr_cmd & AUX_BANK_EN) begin
            unique case (dat_i[1:0])
                CMD_PRIMARY: next_bank = 1'b0;
                CMD_AUX:     next_bank = 1'b1;
                CMD_TOGGLE:  next_bank = ~bank_aux;
                default:     next_bank = bank_aux;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // bus answer: one wait state, ack for exactly one cycle
    // ------------------------------------------------------------------
    // req masks itself with ack_o, so a master that holds its strobe
    // through the ack edge is not taken a second time
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= req;
        end
    end

    // read data holds until the next request, which lets a slow master
    // pick it up late
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (req) begin
            dat_o <= next_dat;
        end
    end

    // ------------------------------------------------------------------
    // I/O words, both banks
    // ------------------------------------------------------------------
    // cleared so all pins start as inputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            main_latch <= RST_WORD;
            main_dir   <= RST_WORD;
        end else begin
            if (wr_main_latch) begin
                main_latch <= wr_merged;
            end
            if (wr_main_dir) begin
                main_dir <= wr_merged;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aux_latch <= RST_WORD;
            aux_dir   <= RST_WORD;
        end else begin
            if (wr_aux_latch) begin
                aux_latch <= wr_merged;
            end
            if (wr_aux_dir) begin
                aux_dir <= wr_merged;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bank_aux <= RST_BANK;
        end else begin
            bank_aux <= next_bank;
        end
    end

    // ------------------------------------------------------------------
    // general words
    // ------------------------------------------------------------------
    // thirteen words in flops: too few for a RAM macro to pay off, and
    // reset can clear them all in one edge
    // word n holds byte 2n low, 2n+1 high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < GP_WORDS; i++) begin
                gp_mem[i] <= RST_WORD;
            end
        end else if (wr_gp) begin
            gp_mem[gp_index] <= wr_merged;
        end
    end

    // ------------------------------------------------------------------
    // pad drivers
    // ------------------------------------------------------------------
    // registered copies so every pad signal leaves from a flip-flop;
    // costs one cycle between a write and the pad change
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_o    <= RST_WORD;
            pin_oe_o <= RST_WORD;
        end else begin
            pin_o    <= main_latch;
            pin_oe_o <= main_dir;
        end
    end

    // the pad value follows the latch whatever the direction; the
    // enable alone decides whether it reaches the pin
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aux_pin_o    <= RST_WORD;
            aux_pin_oe_o <= RST_WORD;
        end else begin
            aux_pin_o    <= AUX_BANK_EN ? aux_latch : RST_WORD;
            aux_pin_oe_o <= AUX_BANK_EN ? aux_dir : RST_WORD;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aux_selected_o <= RST_BANK;
        end else begin
            aux_selected_o <= bank_aux;
        end
    end

endmodule

/* logic/iopvr_pkg.sv */
/*
 * Constants shared by the sixteen-pin I/O port and its variable RAM:
 * Wishbone register offsets, word indices, access granules, bank
 * commands and reset values.
 * Assumes a 32-bit classic Wishbone slave with byte addresses.
 */
package iopvr_pkg;

    // ------------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------------
    localparam int unsigned WORD_BITS  = 16;
    localparam int unsigned WORD_COUNT = 16;
    localparam int unsigned IO_WORDS   = 3;
    localparam int unsigned GP_WORDS   = 13;
    localparam int unsigned ADDR_BITS  = 13;

    // ------------------------------------------------------------------
    // word indices inside the variable RAM
    // ------------------------------------------------------------------
    localparam logic [3:0] WIDX_INPUT = 4'h0;
    localparam logic [3:0] WIDX_LATCH = 4'h1;
    localparam logic [3:0] WIDX_DIR   = 4'h2;
    localparam logic [3:0] WIDX_GP0   = 4'h3;

    // ------------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------------
    // word map: word n at WORD_BASE + 4*n, sel[0] low byte, sel[1] high
    localparam logic [12:0] OFF_WORD_BASE  = 13'h0000;
    localparam logic [12:0] OFF_WORD_LAST  = 13'h003C;
    localparam logic [12:0] OFF_BANK_CMD   = 13'h0040;
    localparam logic [12:0] OFF_BANK_STAT  = 13'h0044;
    // field window: word index = {granule, word, position}
    localparam logic [12:0] OFF_FIELD_BASE = 13'h1000;

    // field window index layout (word index bits)
    localparam int unsigned FLD_POS_LSB = 0;
    localparam int unsigned FLD_WRD_LSB = 4;
    localparam int unsigned FLD_GRN_LSB = 8;

    // ------------------------------------------------------------------
    // access granules
    // ------------------------------------------------------------------
    localparam logic [1:0] GRN_WORD   = 2'h0;
    localparam logic [1:0] GRN_BYTE   = 2'h1;
    localparam logic [1:0] GRN_NIBBLE = 2'h2;
    localparam logic [1:0] GRN_BIT    = 2'h3;

    localparam logic [15:0] MASK_WORD   = 16'hFFFF;
    localparam logic [15:0] MASK_BYTE   = 16'h00FF;
    localparam logic [15:0] MASK_NIBBLE = 16'h000F;
    localparam logic [15:0] MASK_BIT    = 16'h0001;

    // ------------------------------------------------------------------
    // bank select commands (low bits of a write to OFF_BANK_CMD)
    // ------------------------------------------------------------------
    localparam logic [1:0] CMD_PRIMARY = 2'h1;
    localparam logic [1:0] CMD_AUX     = 2'h2;
    localparam logic [1:0] CMD_TOGGLE  = 2'h3;

    // status bits
    localparam int unsigned STAT_AUX_SEL   = 0;
    localparam int unsigned STAT_AUX_AVAIL = 1;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic        RST_BANK = 1'b0;

endpackage

/* bench/iopvr_assertions.sv */
/*
 * Concurrent checks on the ports of the I/O port and variable RAM.
 * Assumes a classic Wishbone master and pins settled on clk_i.
 */
module iopvr_assertions
    import iopvr_pkg::*;
#(
    parameter bit AUX_BANK_EN = 1'b1
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [12:0] adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic [15:0] pin_in_i,
    input wire logic [15:0] pin_o,
    input wire logic [15:0] pin_oe_o,
    input wire logic [15:0] aux_pin_in_i,
    input wire logic [15:0] aux_pin_o,
    input wire logic [15:0] aux_pin_oe_o,
    input wire logic        aux_selected_o
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    logic       take;
    logic [1:0] stable_cnt;
    assign take = cyc_i && stb_i && !ack_o;

    // reads only mean something once the synchroniser has flushed
    always_ff @(posedge clk_i) begin
        if (rst_i || !$stable(pin_in_i)) stable_cnt <= 2'h0;
        else if (stable_cnt != 2'h3) stable_cnt <= stable_cnt + 2'h1;
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_ack_next; take |=> ack_o; endproperty
    a_ack_next: assert property (p_ack_next)
        else $error("ack missing one cycle after request");
    property p_ack_pulse; ack_o |=> !ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack held longer than one cycle");
    property p_dat_upper; ack_o |-> dat_o[31:16] == 16'h0000; endproperty
    a_dat_upper: assert property (p_dat_upper)
        else $error("upper read data not zero");
    property p_rst_pins;
        $fell(rst_i) |-> pin_oe_o == 16'h0000 && pin_o == 16'h0000
            && aux_pin_oe_o == 16'h0000 && !aux_selected_o;
    endproperty
    a_rst_pins: assert property (p_rst_pins)
        else $error("pins or bank not cleared by reset");
    property p_dir_pins;
        take && we_i && adr_i == 13'h0008 && sel_i[1:0] == 2'b11
            && !aux_selected_o |-> ##2 pin_oe_o == $past(dat_i[15:0], 2);
    endproperty
    a_dir_pins: assert property (p_dir_pins)
        else $error("pin enables do not follow direction word");
    property p_latch_pins;
        take && we_i && adr_i == 13'h0004 && sel_i[1:0] == 2'b11
            && !aux_selected_o |-> ##2 pin_o == $past(dat_i[15:0], 2);
    endproperty
    a_latch_pins: assert property (p_latch_pins)
        else $error("pin outputs do not follow latch word");
    property p_in_read;
        take && !we_i && adr_i == 13'h0000 && !aux_selected_o
            && stable_cnt == 2'h3 && $stable(pin_in_i)
            |=> dat_o[15:0] == $past(pin_in_i);
    endproperty
    a_in_read: assert property (p_in_read)
        else $error("input word differs from pin levels");
    property p_aux_sel;
        take && we_i && adr_i == 13'h0040 && sel_i[0] && AUX_BANK_EN
            && dat_i[1:0] == CMD_AUX |-> ##[1:2] aux_selected_o;
    endproperty
    a_aux_sel: assert property (p_aux_sel)
        else $error("auxiliary bank not selected");
    property p_prim_sel;
        take && we_i && adr_i == 13'h0040 && sel_i[0]
            && dat_i[1:0] == CMD_PRIMARY |-> ##[1:2] !aux_selected_o;
    endproperty
    a_prim_sel: assert property (p_prim_sel)
        else $error("main bank not selected");
endmodule

bind iopvr_port iopvr_assertions #(.AUX_BANK_EN(AUX_BANK_EN)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .pin_in_i(pin_in_i), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .aux_pin_in_i(aux_pin_in_i),
    .aux_pin_o(aux_pin_o), .aux_pin_oe_o(aux_pin_oe_o),
    .aux_selected_o(aux_selected_o));

/* bench/iopvr_pins_model.sv */
/*
 * External circuitry on one group of sixteen pins.
 * Assumes a pull-up on every pin; a forcing source beats the port.
 */
module iopvr_pins_model (
    input  wire logic [15:0] drive_i,
    input  wire logic [15:0] drive_en_i,
    input  wire logic [15:0] force_val_i,
    input  wire logic [15:0] force_en_i,
    output logic      [15:0] level_o
);
    // ----------------------------------------
    // pin resolution
    // ----------------------------------------
    // forced level wins
    assign level_o = (force_en_i & force_val_i)
                   | (~force_en_i & drive_en_i & drive_i)
                   | (~force_en_i & ~drive_en_i);
endmodule

/* bench/iopvr_port_tb_top.sv */
/*
 * Self-checking bench for the I/O port and variable RAM.
 * Assumes the pin model on both groups and the bound checker.
 */
module iopvr_port_tb_top
    import iopvr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // stimulus and plumbing
    // ----------------------------------------
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i = 1'b0;
    logic [12:0] adr_i = 13'h0000;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000;
    logic [15:0] ext_en = 16'h0000;
    logic [31:0] dat_o;
    logic        ack_o;
    logic [15:0] pin_in_i, pin_o, pin_oe_o;
    logic [15:0] aux_pin_in_i, aux_pin_o, aux_pin_oe_o;
    logic        aux_selected_o;
    int          err_count = 0;
    int          tests_run = 0;

    always #2 clk_i = ~clk_i;

    iopvr_port u_iopvr_port (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .pin_in_i(pin_in_i),
        .pin_o(pin_o), .pin_oe_o(pin_oe_o), .aux_pin_in_i(aux_pin_in_i),
        .aux_pin_o(aux_pin_o), .aux_pin_oe_o(aux_pin_oe_o),
        .aux_selected_o(aux_selected_o));
    iopvr_pins_model u_main_pins (.drive_i(pin_o), .drive_en_i(pin_oe_o),
        .force_val_i(16'h0000), .force_en_i(ext_en), .level_o(pin_in_i));
    iopvr_pins_model u_aux_pins (.drive_i(aux_pin_o),
        .drive_en_i(aux_pin_oe_o), .force_val_i(16'h0000),
        .force_en_i(16'h0000), .level_o(aux_pin_in_i));

    task automatic summarize;
        if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // one classic cycle; the wait is bounded so a dead slave shows up
    task automatic bus(input logic [12:0] a, input logic w,
                       input logic [3:0] s, input logic [15:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, sel_i} <= {2'b11, w, a, s};
        dat_i <= {16'h0000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        if (ack_o !== 1'b1) err_count++;
        q = dat_o;
        {cyc_i, stb_i} <= 2'b00;
    endtask

    task automatic wr(input logic [12:0] a, input logic [3:0] s,
                      input logic [15:0] d);
        logic [31:0] q;
        bus(a, 1'b1, s, d, q);
    endtask

    task automatic rd(input logic [12:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(a, 1'b0, 4'h3, 16'h0000, q);
        chk($sformatf("adr %h", a), e, q);
    endtask

    function automatic logic [12:0] fa(input logic [1:0] g,
                                       input logic [3:0] w, p);
        return {1'b1, g, w, p, 2'b00};
    endfunction

    task automatic t_reset;
        for (int i = 1; i < 16; i++) rd(13'(4 * i), 32'h0000_0000);
        rd(13'h0000, 32'h0000_FFFF);
        rd(OFF_BANK_STAT, 32'h0000_0002);
        wr(13'h0100, 4'h3, 16'h1234);
        rd(13'h0100, 32'h0000_0000);
    endtask

    task automatic t_pins;
        wr(13'h0004, 4'h3, 16'hA5C3);
        wr(13'h0008, 4'h3, 16'h00FF);
        tick(3);
        chk("pin_oe_o", 32'h0000_00FF, {16'h0000, pin_oe_o});
        chk("pin_o", 32'h0000_A5C3, {16'h0000, pin_o});
        rd(13'h0000, 32'h0000_FFC3);
        ext_en <= 16'h0001;
        tick(3);
        rd(13'h0000, 32'h0000_FFC2);
        wr(13'h0000, 4'h3, 16'h0000);
        rd(13'h0000, 32'h0000_FFC2);
    endtask

    task automatic t_fields;
        wr(13'h000C, 4'h2, 16'hABFF);
        rd(13'h000C, 32'h0000_AB00);
        wr(fa(GRN_BYTE, 4'hF, 4'h1), 4'h3, 16'h005A);
        rd(13'h003C, 32'h0000_5A00);
        rd(fa(GRN_BYTE, 4'h0, 4'h1), 32'h0000_00FF);
        wr(fa(GRN_NIBBLE, 4'h1, 4'h1), 4'h3, 16'h0007);
        rd(13'h0004, 32'h0000_A573);
        rd(fa(GRN_NIBBLE, 4'h1, 4'h3), 32'h0000_000A);
        wr(fa(GRN_BIT, 4'h4, 4'hF), 4'h3, 16'h0001);
        rd(13'h0010, 32'h0000_8000);
        rd(fa(GRN_BIT, 4'h0, 4'h0), 32'h0000_0000);
        rd(fa(GRN_WORD, 4'h2, 4'h0), 32'h0000_00FF);
    endtask

    task automatic t_bank;
        wr(OFF_BANK_CMD, 4'h1, {14'h0000, CMD_AUX});
        rd(OFF_BANK_STAT, 32'h0000_0003);
        wr(13'h0008, 4'h3, 16'h000F);
        tick(3);
        chk("aux_pin_oe_o", 32'h0000_000F, {16'h0000, aux_pin_oe_o});
        chk("pin_oe_o", 32'h0000_00FF, {16'h0000, pin_oe_o});
        rd(13'h0000, 32'h0000_FFF0);
        rd(13'h0004, 32'h0000_0000);
        chk("aux_selected_o", 32'h0000_0001, 32'(aux_selected_o));
        wr(13'h0004, 4'h3, 16'h0005);
        tick(3);
        chk("aux_pin_o", 32'h0000_0005, {16'h0000, aux_pin_o});
        chk("pin_o", 32'h0000_A573, {16'h0000, pin_o});
        wr(OFF_BANK_CMD, 4'h1, {14'h0000, CMD_TOGGLE});
        rd(13'h0004, 32'h0000_A573);
        wr(OFF_BANK_CMD, 4'h1, {14'h0000, CMD_AUX});
        wr(OFF_BANK_CMD, 4'h1, {14'h0000, CMD_PRIMARY});
        rd(OFF_BANK_STAT, 32'h0000_0002);
    endtask

    task automatic t_rereset;
        wr(OFF_BANK_CMD, 4'h1, {14'h0000, CMD_AUX});
        rst_i <= 1'b1;
        tick(2);
        rst_i <= 1'b0;
        rd(13'h0004, 32'h0000_0000);
        rd(13'h0010, 32'h0000_0000);
        rd(OFF_BANK_STAT, 32'h0000_0002);
    endtask

    initial begin
        tick(6);
        rst_i <= 1'b0;
        t_reset;
        t_pins;
        t_fields;
        t_bank;
        t_rereset;
        summarize;
    end

    // under two hundred cycles are expected; this is far beyond them
    initial begin
        #80000;
        err_count++;
        summarize;
    end
endmodule
